// ==== rtl/qwss_pkg.sv ====
// package: constants and types of the quad wiper setting store
// Overview of operation
// - each of four channels has its own 6-bit wiper position driving only its taps
// - each channel keeps four 6-bit stored settings, sixteen in all
// - after reset every wiper position loads its channel's first stored setting
// - exactly one of 64 taps per channel is selected, by the wiper position
// - bytes are answered only after the address matches the four select pins
// - serial data is open drain: pulled low or released, never driven high
// - all serial bits are sampled and shifted on the master's bus clock
// - the master can read and write wiper positions and stored settings
// - instructions copy a wiper position to or from its channel's stored settings
// - an instruction enters a mode that steps a wiper up or down
package qwss_pkg;
  localparam int         NUM_CH    = 4;
  localparam int         NUM_ST    = 4;
  localparam int         NUM_TAPS  = 64;
  localparam int         POS_W     = 6;
  localparam logic [3:0] BUS_PREFIX = 4'h5;
  localparam logic [5:0] POS_MAX   = 6'h3F;
  localparam logic [5:0] POS_MIN   = 6'h00;
  localparam logic [5:0] POS_RST   = 6'h00;
  localparam logic [5:0] ST_RST    = 6'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;
  localparam logic [NUM_TAPS-1:0] TAP_ONE = 64'h0000_0000_0000_0001;

  typedef logic [POS_W-1:0] qwss_pos_t;

  // instruction codes, upper nibble of the instruction byte
  typedef enum logic [3:0] {
    OP_INCDEC   = 4'h2,
    OP_RD_WIPER = 4'h9,
    OP_WR_WIPER = 4'hA,
    OP_RD_STORE = 4'hB,
    OP_WR_STORE = 4'hC,
    OP_RECALL   = 4'hD,
    OP_SAVE     = 4'hE
  } qwss_op_t;

  // byte phase of a frame
  typedef enum logic [2:0] {
    PH_ADDR   = 3'b000,
    PH_INSTR  = 3'b001,
    PH_DATA   = 3'b010,
    PH_RD     = 3'b011,
    PH_IGNORE = 3'b100
  } qwss_phase_t;

  // command passed from the bus clock side to the register side
  typedef struct packed {
    qwss_op_t  op;
    logic [1:0] idx;
    logic [1:0] ch;
    qwss_pos_t data;
  } qwss_cmd_t;
endpackage : qwss_pkg

// ==== rtl/qwss_tap_if.sv ====
// interface: wiper position to tap decoder and its one-hot selects
`timescale 1ns/100ps
`default_nettype none
interface qwss_tap_if;
  logic [5:0]  pos;
  logic [63:0] taps;
  modport ctl (output pos, input taps);
  modport dec (input pos, output taps);
endinterface : qwss_tap_if
`default_nettype wire

// ==== rtl/qwss_tap_decoder.sv ====
// module: one channel's registered one-hot tap switch decoder
`timescale 1ns/100ps
`default_nettype none
module qwss_tap_decoder (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // position in, selects out
  qwss_tap_if.dec   tap
);
  import qwss_pkg::*;

  // one switch closed, chosen by the position
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tap.taps <= TAP_ONE;
    end else begin
      tap.taps <= TAP_ONE << tap.pos;
    end
  end

  property p_onehot;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $onehot(tap.taps);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

  property p_tap_match;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      ##1 tap.taps == (TAP_ONE << $past(tap.pos));
  endproperty
  a_tap_match: assert property (p_tap_match) else $error("tap select not from position");
endmodule : qwss_tap_decoder
`default_nettype wire

// ==== rtl/qwss_top.sv ====
// module: serial bus slave with wiper and stored-setting registers
`timescale 1ns/100ps
`default_nettype none
module qwss_top #(
  parameter qwss_pkg::qwss_pos_t STORED_INIT = qwss_pkg::ST_RST
) (
  // system clock and reset
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  // serial bus: link clock and open-drain data
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // bus address select pins
  input  wire logic bus_select_bit_0_i,
  input  wire logic bus_select_bit_1_i,
  input  wire logic bus_select_bit_2_i,
  input  wire logic bus_select_bit_3_i,
  // tap switch selects, one-hot per channel
  output logic [qwss_pkg::NUM_CH-1:0][qwss_pkg::NUM_TAPS-1:0] tap_sel_o
);
  import qwss_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register side declarations
  qwss_pos_t wiper_q [NUM_CH];
  qwss_pos_t store_q [NUM_CH][NUM_ST];
  qwss_pos_t rd_q;
  logic      recall_q;
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic      frame_q;
  logic      hold_q;
  logic      eng_rst_q;
  logic [2:0] req_s_q;
  logic      start_ev;
  logic      stop_ev;
  logic      exec;

  // bus clock side declarations
  qwss_phase_t phase_q;
  logic [3:0]  cnt_q;
  logic [6:0]  shift_q;
  logic        ack_q;
  logic [3:0]  instr_q;
  logic [3:0]  sel_m_q;
  logic [3:0]  sel_s_q;
  logic        req_tgl_q;
  qwss_cmd_t   cmd_q;
  logic        oe_q;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        addr_hit;
  logic [7:0]  tx_byte;

  ////////////////////////////////////////////////////////////////////////
  // start and stop detection on synchronised pins
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  // data edges while the clock is high mark frame edges
  assign start_ev = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop_ev  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];

  // frame state and engine reset, released once the clock goes low
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_q   <= 1'b0;
      hold_q    <= 1'b0;
      eng_rst_q <= 1'b1;
    end else begin
      if (start_ev) begin
        frame_q <= 1'b1;
        hold_q  <= 1'b1;
      end else if (stop_ev) begin
        frame_q <= 1'b0;
      end else if (!scl_s_q[1]) begin
        hold_q  <= 1'b0;
      end
      eng_rst_q <= start_ev | stop_ev | hold_q | ~frame_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus clock side: address straps pass two flops
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_m_q <= 4'h0;
      sel_s_q <= 4'h0;
    end else begin
      sel_m_q <= {bus_select_bit_3_i, bus_select_bit_2_i,
                  bus_select_bit_1_i, bus_select_bit_0_i};
      sel_s_q <= sel_m_q;
    end
  end

  assign rx_byte   = {shift_q, sda_i};
  assign byte_done = (cnt_q == LAST_BIT);
  assign addr_hit  = (rx_byte[7:1] == {BUS_PREFIX[2:0], sel_s_q});

  // bit counter and shifter, sampled on the rising bus clock
  always_ff @(posedge scl_i or posedge eng_rst_q) begin
    if (eng_rst_q) begin
      cnt_q   <= 4'h0;
      shift_q <= 7'h00;
    end else begin
      shift_q <= rx_byte[6:0];
      cnt_q   <= (cnt_q == BYTE_BITS) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // byte phase of the frame
  always_ff @(posedge scl_i or posedge eng_rst_q) begin
    if (eng_rst_q) begin
      phase_q <= PH_ADDR;
    end else begin
      unique case (phase_q)
        PH_ADDR: begin
          if (byte_done) begin
            if (!addr_hit) begin
              phase_q <= PH_IGNORE;
            end else begin
              phase_q <= rx_byte[0] ? PH_RD : PH_INSTR;
            end
          end
        end
        PH_INSTR: begin
          if (byte_done) begin
            phase_q <= PH_DATA;
          end
        end
        PH_DATA: begin
          phase_q <= PH_DATA;
        end
        PH_RD: begin
          if (cnt_q == BYTE_BITS && sda_i) begin
            phase_q <= PH_IGNORE; // master ended the read
          end
        end
        PH_IGNORE: begin
          phase_q <= PH_IGNORE;
        end
        default: begin
          phase_q <= PH_IGNORE;
        end
      endcase
    end
  end

  // acknowledge owed for the byte just received
  always_ff @(posedge scl_i or posedge eng_rst_q) begin
    if (eng_rst_q) begin
      ack_q <= 1'b0;
    end else if (byte_done) begin
      ack_q <= (phase_q == PH_ADDR && addr_hit)
             | (phase_q == PH_INSTR) | (phase_q == PH_DATA);
    end else begin
      ack_q <= 1'b0;
    end
  end

  // instruction latch and command issue towards the registers
  always_ff @(posedge scl_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      instr_q   <= 4'h0;
      cmd_q     <= '0;
      req_tgl_q <= 1'b0;
    end else if (!eng_rst_q && byte_done) begin
      if (phase_q == PH_INSTR) begin
        // channel and index must come from this frame's instruction byte
        instr_q <= rx_byte[7:4];
        cmd_q   <= {rx_byte, POS_MIN};
        if (rx_byte[7:4] inside {OP_RD_WIPER, OP_RD_STORE,
                                 OP_RECALL, OP_SAVE}) begin
          req_tgl_q <= ~req_tgl_q;
        end
      end else if (phase_q == PH_DATA &&
                   instr_q inside {OP_WR_WIPER, OP_WR_STORE, OP_INCDEC}) begin
        cmd_q.data <= rx_byte[5:0];
        req_tgl_q  <= ~req_tgl_q;
      end
    end
  end

  // read data and ack bits go out on the falling bus clock
  assign tx_byte = {2'b00, rd_q};
  always_ff @(negedge scl_i or posedge eng_rst_q) begin
    if (eng_rst_q) begin
      oe_q <= 1'b0;
    end else if (cnt_q == BYTE_BITS) begin
      oe_q <= ack_q;
    end else begin
      oe_q <= (phase_q == PH_RD) & ~tx_byte[3'(LAST_BIT - cnt_q)];
    end
  end

  // open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // register side: toggle handshake, command word is held stable
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_s_q <= 3'h0;
    end else begin
      req_s_q <= {req_s_q[1:0], req_tgl_q};
    end
  end
  assign exec = req_s_q[2] ^ req_s_q[1];

  // power-up recall flag, one cycle after reset release
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      recall_q <= 1'b1;
    end else begin
      recall_q <= 1'b0;
    end
  end

  // wiper position registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        wiper_q[c] <= POS_RST;
      end
    end else if (recall_q) begin
      for (int c = 0; c < NUM_CH; c++) begin
        wiper_q[c] <= store_q[c][0];
      end
    end else if (exec) begin
      unique case (cmd_q.op)
        OP_WR_WIPER: wiper_q[cmd_q.ch] <= cmd_q.data;
        OP_RECALL:   wiper_q[cmd_q.ch] <= store_q[cmd_q.ch][cmd_q.idx];
        OP_INCDEC: begin
          if (cmd_q.data[0] && wiper_q[cmd_q.ch] != POS_MAX) begin
            wiper_q[cmd_q.ch] <= wiper_q[cmd_q.ch] + 6'h01;
          end else if (!cmd_q.data[0] && wiper_q[cmd_q.ch] != POS_MIN) begin
            wiper_q[cmd_q.ch] <= wiper_q[cmd_q.ch] - 6'h01;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // stored-setting registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int s = 0; s < NUM_ST; s++) begin
          store_q[c][s] <= STORED_INIT;
        end
      end
    end else if (exec && cmd_q.op == OP_WR_STORE) begin
      store_q[cmd_q.ch][cmd_q.idx] <= cmd_q.data;
    end else if (exec && cmd_q.op == OP_SAVE) begin
      store_q[cmd_q.ch][cmd_q.idx] <= wiper_q[cmd_q.ch];
    end
  end

  // read-back value for the next read byte
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_q <= POS_RST;
    end else if (exec) begin
      unique case (cmd_q.op)
        OP_RD_WIPER: rd_q <= wiper_q[cmd_q.ch];
        OP_RD_STORE: rd_q <= store_q[cmd_q.ch][cmd_q.idx];
        OP_WR_WIPER, OP_WR_STORE: rd_q <= cmd_q.data;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one tap decoder per channel
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    qwss_tap_if tap_if ();
    assign tap_if.pos = wiper_q[g];
    assign tap_sel_o[g] = tap_if.taps;
    qwss_tap_decoder u_dec (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .tap       (tap_if.dec)
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_recall;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      recall_q |=> wiper_q[0] == $past(store_q[0][0]) && wiper_q[3] == $past(store_q[3][0]);
  endproperty
  a_recall: assert property (p_recall) else $error("power-up recall missed");

  property p_wr_wiper;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exec && cmd_q.op == OP_WR_WIPER && !recall_q
      |=> wiper_q[$past(cmd_q.ch)] == $past(cmd_q.data)
          && wiper_q[$past(cmd_q.ch) ^ 2'h1] == $past(wiper_q[cmd_q.ch ^ 2'h1]);
  endproperty
  a_wr_wiper: assert property (p_wr_wiper) else $error("wiper write wrong");

  property p_wr_store;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exec && cmd_q.op == OP_WR_STORE |=> store_q[$past(cmd_q.ch)][$past(cmd_q.idx)] == $past(cmd_q.data);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("stored write wrong");

  property p_save;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exec && cmd_q.op == OP_SAVE |=> store_q[$past(cmd_q.ch)][$past(cmd_q.idx)] == $past(wiper_q[cmd_q.ch]);
  endproperty
  a_save: assert property (p_save) else $error("save to stored wrong");

  property p_inc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exec && cmd_q.op == OP_INCDEC && cmd_q.data[0] && wiper_q[cmd_q.ch] != POS_MAX && !recall_q
      |=> wiper_q[$past(cmd_q.ch)] == $past(wiper_q[cmd_q.ch]) + 6'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment step wrong");

  property p_rd;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      exec && cmd_q.op == OP_RD_WIPER |=> rd_q == $past(wiper_q[cmd_q.ch]);
  endproperty
  a_rd: assert property (p_rd) else $error("read-back wrong");

  property p_exec_lat;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $changed(req_tgl_q) |-> ##[2:3] exec;
  endproperty
  a_exec_lat: assert property (p_exec_lat) else $error("command not taken in time");

  property p_addr_miss;
    @(posedge scl_i) disable iff (eng_rst_q)
      phase_q == PH_ADDR && byte_done && !addr_hit |=> !ack_q && phase_q == PH_IGNORE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("acked foreign address");

  property p_no_ack_idle;
    @(negedge scl_i) disable iff (eng_rst_q)
      phase_q == PH_IGNORE |=> !sda_oe_o;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle) else $error("drove bus unaddressed");

  property p_open_drain;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      sda_oe_o |-> !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");

  c_wr_wiper: cover property (@(posedge ref_clk_i) exec && cmd_q.op == OP_WR_WIPER);
  c_incdec:   cover property (@(posedge ref_clk_i) exec && cmd_q.op == OP_INCDEC);
  c_read:     cover property (@(posedge scl_i) phase_q == PH_RD && cnt_q == BYTE_BITS);
  c_save:     cover property (@(posedge ref_clk_i) exec && cmd_q.op == OP_SAVE);
endmodule : qwss_top
`default_nettype wire

// ==== test/qwss_master.sv ====
// partner: serial bus master that makes the link clock and pulls data low
`timescale 1ns/100ps
`default_nettype none
module qwss_master (
  // bus pins
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  localparam int HALF = 15;
  localparam int HOLD = 200;
  // clock rests high between frames, data released
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // one clock pulse; the line is taken at the rising edge
  task automatic pulse(output logic s);
    #HALF scl_o = 1'b1;
    s = sda_i;
    #HALF scl_o = 1'b0;
  endtask : pulse
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_oe_o = 1'b0;
    #HOLD scl_o = 1'b1;
    #HOLD sda_oe_o = 1'b1;
    #HOLD scl_o = 1'b0;
    #HOLD;
  endtask : start
  // stop: data rises while clock is high
  task automatic stop();
    sda_oe_o = 1'b1;
    #HOLD scl_o = 1'b1;
    #HOLD sda_oe_o = 1'b0;
    #HOLD;
  endtask : stop
  // send a byte msb first, then sample the acknowledge bit
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o = ~b[i];
      pulse(s);
    end
    sda_oe_o = 1'b0;
    pulse(s);
    ack = ~s;
  endtask : send
  // take a byte msb first, then answer ack or nack
  task automatic recv(input logic nack, output logic [7:0] b);
    logic s;
    sda_oe_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_oe_o = ~nack;
    pulse(s);
    sda_oe_o = 1'b0;
  endtask : recv
endmodule : qwss_master
`default_nettype wire

// ==== test/qwss_bench.sv ====
// bench: self-checking run of the quad wiper setting store
`timescale 1ns/100ps
`default_nettype none
module qwss_bench;
  import qwss_pkg::*;
  localparam qwss_pos_t INIT = 6'h15;
  logic                            ref_clk, sys_rst, scl, sda, sda_o, sda_oe, m_oe, ack;
  logic [3:0]                      pins;
  logic [7:0]                      rb;
  logic [7:0]                      nd [$];
  logic [NUM_CH-1:0][NUM_TAPS-1:0] taps;
  qwss_pos_t                       wip [NUM_CH];
  qwss_pos_t                       st [NUM_CH][NUM_ST];
  int                              fails, checks, seed;
  logic [1:0]                      c, k;
  qwss_pos_t                       v;

  qwss_top #(.STORED_INIT(INIT)) i_dut (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .bus_select_bit_0_i(pins[0]), .bus_select_bit_1_i(pins[1]), .bus_select_bit_2_i(pins[2]),
    .bus_select_bit_3_i(pins[3]), .tap_sel_o(taps));
  qwss_master i_master (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

  // open-drain data line with pull-up
  assign sda = ~(m_oe | (sda_oe & ~sda_o));
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [63:0] onehot(input qwss_pos_t p);
    return TAP_ONE << p;
  endfunction : onehot
  function automatic logic [7:0] abyte(input logic [3:0] p, input logic r);
    return {BUS_PREFIX[2:0], p, r};
  endfunction : abyte
  task automatic taps_chk();
    @(negedge ref_clk);
    for (int i = 0; i < NUM_CH; i++) chk(taps[i], onehot(wip[i]));
  endtask : taps_chk
  // write frame: address, instruction, data bytes
  task automatic wr(input logic [3:0] op, input logic [1:0] idx, input logic [1:0] ch, input logic [7:0] d [$]);
    i_master.start();
    i_master.send(abyte(pins, 1'b0), ack);
    chk(ack, 1'b1);
    i_master.send({op, idx, ch}, ack);
    chk(ack, 1'b1);
    foreach (d[i]) begin
      i_master.send(d[i], ack);
      chk(ack, 1'b1);
    end
    i_master.stop();
    repeat (2) @(posedge ref_clk);
  endtask : wr
  // read frame through a repeated start
  task automatic rd(input logic [3:0] op, input logic [1:0] idx, input logic [1:0] ch, input qwss_pos_t exp);
    i_master.start();
    i_master.send(abyte(pins, 1'b0), ack);
    i_master.send({op, idx, ch}, ack);
    i_master.start();
    i_master.send(abyte(pins, 1'b1), ack);
    chk(ack, 1'b1);
    i_master.recv(1'b1, rb);
    chk(rb, {2'b00, exp});
    i_master.stop();
  endtask : rd
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////
  // data only ever pulled low
  always @(posedge ref_clk) begin
    if (sda_oe === 1'b1) chk(sda_o, 1'b0);
  end
  // watchdog well beyond the expected run
  initial begin
    #2000000;
    fails++;
    $display("watchdog expired");
    end_of_test();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    pins    = 4'h0;
    fails   = 0;
    checks  = 0;
    seed    = $urandom(12447);
    foreach (wip[i]) wip[i] = INIT;
    foreach (st[i, j]) st[i][j] = INIT;
    @(negedge ref_clk) pins = 4'($urandom);
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    taps_chk();
    $display("test power_up done");
    // random wiper writes, upper data bits random, read back
    repeat (6) begin
      c = 2'($urandom);
      v = 6'($urandom);
      wr(OP_WR_WIPER, 2'h0, c, '{{2'($urandom), v}});
      wip[c] = v;
      taps_chk();
      rd(OP_RD_WIPER, 2'h0, c, v);
    end
    // unknown instruction leaves everything alone
    wr(4'h0, 2'h0, c, '{8'h3F});
    taps_chk();
    $display("test wiper_rw done");
    // all sixteen stored settings written, then read
    for (int i = 0; i < NUM_CH; i++) begin
      for (int j = 0; j < NUM_ST; j++) begin
        st[i][j] = 6'($urandom);
        wr(OP_WR_STORE, 2'(j), 2'(i), '{{2'b00, st[i][j]}});
      end
    end
    foreach (st[i, j]) rd(OP_RD_STORE, 2'(j), 2'(i), st[i][j]);
    // save to a stored slot, overwrite, recall
    c = 2'($urandom);
    k = 2'($urandom);
    v = 6'($urandom);
    wr(OP_WR_WIPER, 2'h0, c, '{{2'b00, v}});
    wr(OP_SAVE, k, c, nd);
    wr(OP_WR_WIPER, 2'h0, c, '{{2'b00, ~v}});
    wr(OP_RECALL, k, c, nd);
    wip[c] = v;
    st[c][k] = v;
    taps_chk();
    rd(OP_RD_STORE, k, c, v);
    $display("test stored done");
    // step at both ends of the range: saturation shows in the result
    wr(OP_WR_WIPER, 2'h0, c, '{8'h3E});
    wr(OP_INCDEC, 2'h0, c, '{8'h01, 8'h01, 8'h00});
    wip[c] = 6'h3E;
    taps_chk();
    wr(OP_WR_WIPER, 2'h0, c, '{8'h01});
    wr(OP_INCDEC, 2'h0, c, '{8'h00, 8'h00, 8'h01});
    wip[c] = 6'h01;
    taps_chk();
    $display("test incdec done");
    // pins change; old address and wrong prefix are ignored
    @(negedge ref_clk) pins = ~pins;
    for (int i = 0; i < 2; i++) begin
      i_master.start();
      i_master.send(i == 0 ? abyte(~pins, 1'b0) : {3'b100, pins, 1'b0}, ack);
      chk(ack, 1'b0);
      i_master.send({OP_WR_WIPER, 2'h0, c}, ack);
      chk(ack, 1'b0);
      i_master.send(8'h2A, ack);
      i_master.stop();
      taps_chk();
    end
    wr(OP_WR_WIPER, 2'h0, c, '{8'h2A});
    wip[c] = 6'h2A;
    taps_chk();
    $display("test address done");
    end_of_test();
  end
endmodule : qwss_bench
`default_nettype wire
